// File: rtl/sicr_pkg.sv
package sicr_pkg;
    localparam logic [7:0] SICR_OFF_LINK_CFG    = 8'h3d;
    localparam logic [7:0] SICR_OFF_PRODUCT_ID  = 8'h3e;
    localparam logic [7:0] SICR_OFF_TARGET_ADDR = 8'h3f;
    localparam logic [7:0] SICR_RST_LINK_CFG    = 8'h00;
    localparam logic [7:0] SICR_RST_PRODUCT_ID  = 8'h00;
    localparam logic [7:0] SICR_RST_TARGET_ADDR = 8'h00;
    // field positions in the serial link config byte
    localparam int SICR_POS_STATUS_FMT = 7;
    localparam int SICR_POS_WIDTH_SEL  = 6;
    localparam int SICR_POS_LEN_HI     = 5;
    localparam int SICR_POS_LEN_LO     = 4;
    localparam int SICR_POS_SEED_HI    = 3;
    localparam int SICR_POS_SEED_LO    = 0;
    localparam logic [7:0] SICR_DEF_TARGET   = 8'h60;
    localparam logic [7:0] SICR_ALT_ZERO_ADR = 8'h80;
    localparam logic [7:0] SICR_POLY8        = 8'h2f;
    localparam logic [7:0] SICR_POLY4        = 8'h01;
    localparam logic [7:0] SICR_POLY3        = 8'h03;
    localparam logic [7:0] SICR_SEED8_DEF    = 8'hff;
    localparam logic [3:0] SICR_SEED8_HI     = 4'hf;
    localparam logic [7:0] SICR_SEED4_DEF    = 8'h0a;
    localparam logic [7:0] SICR_SEED3_DEF    = 8'h07;
    localparam logic [3:0] SICR_DATA_W12     = 4'hc;
    localparam logic [3:0] SICR_DATA_W16     = 4'h0;
    localparam int SICR_NREGS = 3;

    typedef enum logic [1:0] {SICR_MODE_DSI3, SICR_MODE_PSI5, SICR_MODE_SPI, SICR_MODE_I2C} sicr_mode_t;
    typedef enum logic [1:0] {SICR_CRC8, SICR_CRC4, SICR_CRC3} sicr_crc_len_t;

    typedef struct packed {
        logic          status_alt;
        logic [4:0]    data_bits;
        sicr_crc_len_t crc_len;
        logic [7:0]    crc_poly;
        logic [7:0]    crc_seed;
        logic          spi_active;
    } sicr_spi_cfg_t;
endpackage : sicr_pkg

// File: rtl/sicr_regfile.sv
`timescale 1ns/1ps
`default_nettype none
// small register array with registered read data and parity per entry
module sicr_regfile
    import sicr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 3
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [WIDTH-1:0]         rst_vals [DEPTH],
    output logic      [WIDTH-1:0]         cur_vals [DEPTH],
    output logic                          parity_err
);
    logic [DEPTH-1:0] par_reg;
    logic [DEPTH-1:0] bad;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            // reset clears every entry to zero; the rst_vals input tied at the instance is not used
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cur_vals[g] <= '0;
                    par_reg[g]  <= 1'b0;
                end else if (wr_en && wr_idx == ($clog2(DEPTH))'(g)) begin
                    cur_vals[g] <= wr_data;
                    par_reg[g]  <= ^wr_data;
                end
            end
            assign bad[g] = (^cur_vals[g]) != par_reg[g];
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            parity_err <= 1'b0;
        end else begin
            parity_err <= |bad;
        end
    end
endmodule : sicr_regfile
`default_nettype wire

// File: rtl/sicr_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - status format bit selects primary or alternate SPI status reporting scheme.
// - data width bit selects 12-bit or 16-bit SPI data field.
// - outside SPI mode these bits store and read back but act on nothing.
// - length code 00 gives CRC8 poly 0x2f, zero seed means 0xff.
// - code 01 gives x^4+1 seed 1010; codes 10,11 give x^3+x+1 seed 111.
// - non-zero seed field replaces default; CRC8 keeps upper nibble 1111.
// - new CRC length takes effect from the next SPI command only.
// - new CRC seed takes effect from the next SPI command only.
// - product identifier reads a fixed code while stored value is zero.
// - address 0x00 or 0x80 answers at 0x60 and reads 0x60.
// - other address values use low 7 bits, read back whole.
// - all three registers read and write in every interface mode.
// - each register is covered by the array error check.
module sicr_top
    import sicr_pkg::*;
#(
    parameter logic [7:0] PRODUCT_CODE = 8'h5a  // arbitrary value
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire sicr_mode_t    if_mode,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    output logic      [7:0]    reg_rdata,
    output logic               reg_hit,
    input  wire logic          spi_cmd_start,
    output sicr_spi_cfg_t      spi_cfg,
    output logic      [6:0]    i2c_target_addr,
    output logic               array_err
);
    logic [7:0] rst_vals [SICR_NREGS];
    logic [7:0] vals     [SICR_NREGS];
    logic       wr_en;
    logic [1:0] wr_idx;
    logic       hit_idx;
    logic [1:0] rd_idx;
    logic [7:0] link_cfg;
    logic [7:0] prod_id;
    logic [7:0] tgt_addr;
    logic [7:0] prod_read;
    logic [7:0] tgt_read;
    logic [3:0] seed_f;
    logic [1:0] len_f;
    sicr_crc_len_t len_sel;
    logic [7:0] poly_sel;
    logic [7:0] seed_sel;
    logic       tgt_default;

    assign rst_vals[0] = SICR_RST_LINK_CFG;
    assign rst_vals[1] = SICR_RST_PRODUCT_ID;
    assign rst_vals[2] = SICR_RST_TARGET_ADDR;

    always_comb begin
        hit_idx = 1'b1;
        rd_idx  = 2'd0;
        case (reg_addr)
            SICR_OFF_LINK_CFG:    rd_idx = 2'd0;
            SICR_OFF_PRODUCT_ID:  rd_idx = 2'd1;
            SICR_OFF_TARGET_ADDR: rd_idx = 2'd2;
            default:              hit_idx = 1'b0;
        endcase
    end

    // mode is not consulted: writes go through in every interface mode
    assign wr_en  = reg_wr && hit_idx;
    assign wr_idx = rd_idx;

    sicr_regfile #(
        .WIDTH (8),
        .DEPTH (SICR_NREGS)
    ) u_regs (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .wr_en      (wr_en),
        .wr_idx     (wr_idx),
        .wr_data    (reg_wdata),
        .rst_vals   (rst_vals),
        .cur_vals   (vals),
        .parity_err (array_err)
    );

    assign link_cfg = vals[0];
    assign prod_id  = vals[1];
    assign tgt_addr = vals[2];

    // substitution on the read path and the bus address output, storage keeps the raw byte
    assign prod_read   = (prod_id == 8'h00) ? PRODUCT_CODE : prod_id;
    assign tgt_default = (tgt_addr == 8'h00) || (tgt_addr == SICR_ALT_ZERO_ADR);
    assign tgt_read    = tgt_default ? SICR_DEF_TARGET : tgt_addr;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end else if (reg_rd) begin
            reg_hit <= hit_idx;
            case (rd_idx)
                2'd0:    reg_rdata <= hit_idx ? link_cfg : 8'h00;
                2'd1:    reg_rdata <= prod_read;
                2'd2:    reg_rdata <= tgt_read;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            i2c_target_addr <= SICR_DEF_TARGET[6:0];
        end else begin
            i2c_target_addr <= tgt_default ? SICR_DEF_TARGET[6:0] : tgt_addr[6:0];
        end
    end

    assign len_f  = link_cfg[SICR_POS_LEN_HI:SICR_POS_LEN_LO];
    assign seed_f = link_cfg[SICR_POS_SEED_HI:SICR_POS_SEED_LO];

    always_comb begin
        len_sel  = SICR_CRC8;
        poly_sel = SICR_POLY8;
        seed_sel = SICR_SEED8_DEF;
        case (len_f)
            2'b00: begin
                len_sel  = SICR_CRC8;
                poly_sel = SICR_POLY8;
                seed_sel = (seed_f == 4'h0) ? SICR_SEED8_DEF : {SICR_SEED8_HI, seed_f};
            end
            2'b01: begin
                len_sel  = SICR_CRC4;
                poly_sel = SICR_POLY4;
                seed_sel = (seed_f == 4'h0) ? SICR_SEED4_DEF : {4'h0, seed_f};
            end
            default: begin
                len_sel  = SICR_CRC3;
                poly_sel = SICR_POLY3;
                seed_sel = (seed_f == 4'h0) ? SICR_SEED3_DEF : {5'h00, seed_f[2:0]};
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            spi_cfg <= '{status_alt: 1'b0, data_bits: 5'd12, crc_len: SICR_CRC8,
                         crc_poly: SICR_POLY8, crc_seed: SICR_SEED8_DEF, spi_active: 1'b0};
        end else begin
            // outside spi mode the fields read back but spi_active gates their use
            spi_cfg.spi_active <= (if_mode == SICR_MODE_SPI);
            spi_cfg.status_alt <= link_cfg[SICR_POS_STATUS_FMT];
            spi_cfg.data_bits  <= link_cfg[SICR_POS_WIDTH_SEL] ? 5'd16 : 5'd12;
            // crc settings are frozen per command so a mid-command write cannot disturb it
            if (spi_cmd_start) begin
                spi_cfg.crc_len  <= len_sel;
                spi_cfg.crc_poly <= poly_sel;
                spi_cfg.crc_seed <= seed_sel;
            end
        end
    end
endmodule : sicr_top
`default_nettype wire

// File: verif/sicr_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sicr_top_chk
    import sicr_pkg::*;
#(
    parameter logic [7:0] PRODUCT_CODE = 8'h5a
) (
    input wire logic          core_clk,
    input wire logic          rst_n,
    input wire sicr_mode_t    if_mode,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [7:0]    reg_addr,
    input wire logic [7:0]    reg_wdata,
    input wire logic [7:0]    reg_rdata,
    input wire logic          reg_hit,
    input wire logic          spi_cmd_start,
    input wire sicr_spi_cfg_t spi_cfg,
    input wire logic [6:0]    i2c_target_addr,
    input wire logic          array_err
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic mapped = (reg_addr >= SICR_OFF_LINK_CFG) && (reg_addr <= SICR_OFF_TARGET_ADDR);
    unmapped_read_a: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
        else $error("unmapped read answered");
    id_subst_a: assert property (reg_rd && reg_addr == SICR_OFF_PRODUCT_ID |=> reg_rdata != 8'h00)
        else $error("identifier read zero");
    adr_subst_a: assert property (reg_rd && reg_addr == SICR_OFF_TARGET_ADDR |=> reg_rdata != 8'h00 && reg_rdata != 8'h80)
        else $error("address read not substituted");
    // three quiet cycles let the address output settle past the two-cycle update
    adr_follow_a: assert property (
        (reg_rd && !reg_wr && reg_addr == SICR_OFF_TARGET_ADDR) ##1 (!reg_wr)[*3]
        |-> i2c_target_addr == $past(reg_rdata[6:0], 2))
        else $error("bus address differs from read");
    fmt_follow_a: assert property (
        (reg_rd && !reg_wr && reg_addr == SICR_OFF_LINK_CFG) ##1 (!reg_wr)[*3]
        |-> spi_cfg.status_alt == $past(reg_rdata[7], 2)
            && spi_cfg.data_bits == ($past(reg_rdata[6], 2) ? 5'h10 : 5'h0c))
        else $error("format or width wrong");
    crc_hold_a: assert property (!spi_cmd_start |=> $stable(spi_cfg.crc_len) && $stable(spi_cfg.crc_seed) && $stable(spi_cfg.crc_poly))
        else $error("crc changed without command");
    crc8_form_a: assert property (spi_cfg.crc_len == SICR_CRC8 |-> spi_cfg.crc_poly == SICR_POLY8 && spi_cfg.crc_seed[7:4] == SICR_SEED8_HI)
        else $error("crc8 setting wrong");
    crc_short_a: assert property (
        spi_cfg.crc_len != SICR_CRC8 |-> spi_cfg.crc_seed[7:4] == 4'h0
        && spi_cfg.crc_poly == ((spi_cfg.crc_len == SICR_CRC4) ? SICR_POLY4 : SICR_POLY3))
        else $error("short crc setting wrong");
    cover property (spi_cmd_start ##1 spi_cfg.crc_len == SICR_CRC3);
    cover property (reg_rd && !mapped);
    cover property (reg_rd && reg_addr == SICR_OFF_TARGET_ADDR ##1 reg_rdata == SICR_DEF_TARGET);
endmodule : sicr_top_chk
bind sicr_top sicr_top_chk #(.PRODUCT_CODE(PRODUCT_CODE)) sicr_top_chk_inst (.*);
`default_nettype wire

// File: verif/sicr_host.sv
`timescale 1ns/1ps
`default_nettype none
module sicr_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0,
    output logic      [7:0] reg_addr = 8'h00,
    output logic      [7:0] reg_wdata = 8'h00
);
    // idle lines carry the inverse so a stale value is never taken as live
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : rd
endmodule : sicr_host
`default_nettype wire

// File: verif/sicr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sicr_top_bench;
    import sicr_pkg::*;
    localparam logic [7:0] CODE = 8'h5a;  // arbitrary value
    logic          core_clk, rst_n, reg_wr, reg_rd, reg_hit, spi_cmd_start, array_err;
    logic [7:0]    reg_addr, reg_wdata, reg_rdata, rv, ev;
    logic [6:0]    i2c_target_addr;
    sicr_mode_t    if_mode;
    sicr_spi_cfg_t spi_cfg, was;
    int            error_cnt, tests_run;
    logic [7:0]    wv [4] = '{8'h00, 8'ha7, 8'h80, 8'h91};
    sicr_top #(.PRODUCT_CODE(CODE)) sicr_top_inst (.core_clk(core_clk), .rst_n(rst_n), .if_mode(if_mode),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .spi_cmd_start(spi_cmd_start), .spi_cfg(spi_cfg),
        .i2c_target_addr(i2c_target_addr), .array_err(array_err));
    sicr_host sicr_host_inst (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("mismatches=%0d checks=%0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task automatic crc_case(input logic [7:0] c, input sicr_crc_len_t l, input logic [7:0] p, input logic [7:0] s);
        was = spi_cfg;
        sicr_host_inst.wr(SICR_OFF_LINK_CFG, c);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk({6'h00, spi_cfg.crc_len}, {6'h00, was.crc_len});
        chk(spi_cfg.crc_seed, was.crc_seed);
        @(posedge core_clk);
        spi_cmd_start <= 1'b1;
        @(posedge core_clk);
        spi_cmd_start <= 1'b0;
        @(negedge core_clk);
        chk({6'h00, spi_cfg.crc_len}, {6'h00, l});
        chk(spi_cfg.crc_poly, p);
        chk(spi_cfg.crc_seed, s);
        chk({7'h00, spi_cfg.status_alt}, {7'h00, c[7]});
        chk({3'h0, spi_cfg.data_bits}, c[6] ? 8'h10 : 8'h0c);
    endtask : crc_case
    initial begin
        rst_n = 1'b0;
        if_mode = SICR_MODE_SPI;
        spi_cmd_start = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk(spi_cfg.crc_seed, SICR_SEED8_DEF);
        chk({1'b0, i2c_target_addr}, SICR_DEF_TARGET);
        crc_case(8'h05, SICR_CRC8, SICR_POLY8, 8'hf5);
        crc_case(8'h10, SICR_CRC4, SICR_POLY4, SICR_SEED4_DEF);
        crc_case(8'h5c, SICR_CRC4, SICR_POLY4, 8'h0c);
        crc_case(8'ha0, SICR_CRC3, SICR_POLY3, SICR_SEED3_DEF);
        crc_case(8'hfd, SICR_CRC3, SICR_POLY3, 8'h05);
        crc_case(8'h80, SICR_CRC8, SICR_POLY8, SICR_SEED8_DEF);
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            if_mode <= sicr_mode_t'(m);
            sicr_host_inst.wr(SICR_OFF_LINK_CFG, ~wv[m]);
            sicr_host_inst.rd(SICR_OFF_LINK_CFG, rv);
            chk(rv, ~wv[m]);
            sicr_host_inst.wr(SICR_OFF_PRODUCT_ID, wv[m]);
            sicr_host_inst.rd(SICR_OFF_PRODUCT_ID, rv);
            chk(rv, (wv[m] == 8'h00) ? CODE : wv[m]);
            sicr_host_inst.wr(SICR_OFF_TARGET_ADDR, wv[m]);
            sicr_host_inst.rd(SICR_OFF_TARGET_ADDR, rv);
            ev = (wv[m][6:0] == 7'h00) ? SICR_DEF_TARGET : wv[m];
            chk(rv, ev);
            repeat (2) @(negedge core_clk);
            chk({1'b0, i2c_target_addr}, {1'b0, ev[6:0]});
        end
        sicr_host_inst.wr(8'h3c, 8'h55);
        sicr_host_inst.rd(8'h3c, rv);
        chk({reg_hit, rv[6:0]}, 8'h00);
        sicr_host_inst.rd(SICR_OFF_TARGET_ADDR, rv);
        chk({7'h00, reg_hit}, 8'h01);
        chk({7'h00, array_err}, 8'h00);
        results();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        results();
    end
endmodule : sicr_top_bench
`default_nettype wire
